// ==== ewh_pkg.sv ====
// constants and types for the external bus wait and hold controller
package ewh_pkg;
	localparam int          EWH_ADDR_W       = 23;
	localparam int          EWH_EXT_LSB      = 16;
	localparam int          EWH_SWS_W        = 3;
	localparam int          EWH_DATA_W       = 16;
	localparam logic [2:0]  EWH_MIN_SWS      = 3'h2;
	localparam logic [1:0]  EWH_HOLD_MIN_CYC = 2'h1;
	localparam logic [1:0]  EWH_SP_PROG      = 2'h0;
	localparam logic [1:0]  EWH_SP_DATA      = 2'h1;
	localparam logic [1:0]  EWH_SP_IO        = 2'h2;
	localparam logic [22:0] EWH_ADDR_RST     = 23'h00_0000;
	typedef enum logic [2:0] {EWH_IDLE, EWH_SETUP, EWH_SWAIT, EWH_RWAIT, EWH_END,
		EWH_HOLD, EWH_REDRIVE} ewh_state_t;
endpackage

// ==== ewh_sync_if.sv ====
// carrier for synchronised pin levels between sampler and controller
interface ewh_sync_if;
	logic ready_s;
	logic hold_req_s;
	modport src (output ready_s, output hold_req_s);
	modport dst (input ready_s, input hold_req_s);
endinterface

// ==== ewh_pin_sync.sv ====
// three-stage pin synchroniser with second/third agreement filter
module ewh_pin_sync (
	input  wire logic mclk,       // system clock
	input  wire logic rst,        // async reset, high
	input  wire logic ce,         // clock enable
	input  wire logic ready_pin,  // external ready
	input  wire logic hold_req_n, // external hold request, low
	ewh_sync_if.src   so          // filtered levels
);
	logic [2:0] rdy_reg;
	logic [2:0] hld_reg;
	logic       rdy_q_reg;
	logic       hld_q_reg;
	wire        rdy_agree = (rdy_reg[1] == rdy_reg[2]);
	wire        hld_agree = (hld_reg[1] == hld_reg[2]);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdy_reg   <= 3'h0;
			hld_reg   <= 3'h0;
			rdy_q_reg <= 1'b0;
			hld_q_reg <= 1'b0;
		end else if (ce) begin
			rdy_reg <= {rdy_reg[1:0], ready_pin};
			hld_reg <= {hld_reg[1:0], ~hold_req_n};
			if (rdy_agree)
				rdy_q_reg <= rdy_reg[2];
			if (hld_agree)
				hld_q_reg <= hld_reg[2];
		end
	end
	assign so.ready_s    = rdy_q_reg;
	assign so.hold_req_s = hld_q_reg;
endmodule

// ==== ewh_bus_ctrl.sv ====
// external bus cycle control with ready wait states and bus hold
// Summary of operation
// RULE1 - ready adds wait states only with at least two software waits
// RULE2 - ready is not sampled before the software waits have elapsed
// RULE3 - ready and hold request are sampled on the clock after synchronising
// RULE4 - a granted hold floats address, selects, read/write and strobes
// RULE5 - hold grant goes low to give the bus, high to take it back
// RULE6 - the external master holds its request low over two clock cycles
// RULE7 - hold grant stays low for at least one full clock cycle
// RULE8 - upper address bits carry dma addresses, core ones only in program space
// RULE9 - after hold, grant rises and the bus is re-driven before new cycles
// RULE10 - address, selects, read/write and strobe stay stable through waits
module ewh_bus_ctrl
	import ewh_pkg::*;
#(
	parameter int ADDR_W = EWH_ADDR_W,
	parameter int SWS_W  = EWH_SWS_W
) (
	input  wire logic              mclk,          // system clock, 40 MHz
	input  wire logic              rst,           // async reset, high
	input  wire logic              ce,            // clock enable
	input  wire logic              req_valid,     // start a bus cycle
	input  wire logic              req_write,     // 1 write, 0 read
	input  wire logic [1:0]        req_space,     // program, data or io
	input  wire logic              req_dma,       // cycle issued by dma
	input  wire logic [ADDR_W-1:0] req_addr,      // full address
	input  wire logic [SWS_W-1:0]  req_sws,       // software wait states
	input  wire logic              ready_pin,     // external ready
	input  wire logic              hold_req_n,    // hold request, low
	output logic                   req_ready,     // request taken
	output logic                   cyc_done,      // cycle finished pulse
	output logic [ADDR_W-1:0]      addr_o,        // address out
	output logic                   addr_oe,       // address/select enable
	output logic                   program_space_sel_n, // program select
	output logic                   data_space_sel_n,    // data select
	output logic                   io_space_sel_n,      // io select
	output logic                   rw_o,          // 1 read, 0 write
	output logic                   rw_oe,         // read/write enable
	output logic                   mem_strobe_n,  // memory strobe
	output logic                   io_strobe_n,   // io strobe
	output logic                   strb_oe,       // strobe enable
	output logic                   bus_hold_grant_n, // hold grant, low
	output logic                   micro_state_complete // low in last state
);
	localparam int EXT_W = ADDR_W - EWH_EXT_LSB;

	ewh_sync_if sync_if ();

	logic              ready_s;
	logic              hold_s;

	ewh_state_t        state_reg;
	ewh_state_t        state_next;
	logic [SWS_W-1:0]  sws_reg;
	logic [SWS_W-1:0]  sws_next;
	logic [SWS_W-1:0]  wcnt_reg;
	logic [SWS_W-1:0]  wcnt_next;
	logic [1:0]        hcnt_reg;
	logic [1:0]        hcnt_next;
	logic              write_reg;
	logic              write_next;
	logic              io_reg;
	logic              io_next;
	logic [1:0]        space_reg;
	logic [1:0]        space_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;

	logic              req_ready_reg;
	logic              cyc_done_reg;
	logic              bus_oe_reg;
	logic              prog_sel_n_reg;
	logic              data_sel_n_reg;
	logic              io_sel_n_reg;
	logic              rw_reg;
	logic              mem_strb_n_reg;
	logic              io_strb_n_reg;
	logic              grant_n_reg;
	logic              msc_reg;

	// RULE8 extended address gating
	function automatic logic [ADDR_W-1:0] ext_addr(
		input logic [ADDR_W-1:0] addr,
		input logic              dma,
		input logic [1:0]        space
	);
		logic [ADDR_W-1:0] res;
		res = addr;
		if (!dma && space != EWH_SP_PROG) begin
			res[ADDR_W-1:EWH_EXT_LSB] = {EXT_W{1'b0}};
		end
		return res;
	endfunction

	// cycle in flight towards one space
	function automatic logic space_hit(
		input ewh_state_t st,
		input logic [1:0] space,
		input logic [1:0] code
	);
		logic busy;
		busy = (st == EWH_SETUP) || (st == EWH_SWAIT) || (st == EWH_RWAIT) || (st == EWH_END);
		return busy && (space == code);
	endfunction

	// RULE3 pin sampling and filtering
	ewh_pin_sync sync_u (
		.mclk       (mclk),
		.rst        (rst),
		.ce         (ce),
		.ready_pin  (ready_pin),
		.hold_req_n (hold_req_n),
		.so         (sync_if)
	);

	assign ready_s = sync_if.ready_s;
	assign hold_s  = sync_if.hold_req_s;

	wire              take_req    = req_valid && req_ready_reg;
	wire              is_io_req   = (req_space == EWH_SP_IO);
	wire [ADDR_W-1:0] req_addr_x  = ext_addr(req_addr, req_dma, req_space);
	// RULE1 ready needs two software waits
	wire              ready_used  = (sws_reg >= SWS_W'(EWH_MIN_SWS));
	wire              sws_last    = (wcnt_reg == SWS_W'(1));
	wire              hold_min_ok = (hcnt_reg == 2'h0);

	wire              next_strobe = (state_next == EWH_SWAIT) || (state_next == EWH_RWAIT) ||
		(state_next == EWH_END);
	wire              next_cyc    = next_strobe || (state_next == EWH_SETUP);
	wire              next_hold   = (state_next == EWH_HOLD);
	wire              next_idle   = (state_next == EWH_IDLE);
	wire              next_last   = (state_next == EWH_END);

	wire              req_ready_next  = next_idle && !hold_s;
	wire              cyc_done_next   = (state_reg == EWH_END);
	// RULE4 float bus during hold
	wire              bus_oe_next     = !next_hold;
	// RULE5 grant low while held
	wire              grant_n_next    = !next_hold;
	wire              prog_sel_n_next = !space_hit(state_next, space_next, EWH_SP_PROG);
	wire              data_sel_n_next = !space_hit(state_next, space_next, EWH_SP_DATA);
	wire              io_sel_n_next   = !space_hit(state_next, space_next, EWH_SP_IO);
	wire              rw_next         = !(next_cyc && write_next);
	// RULE10 strobe held through waits
	wire              mem_strb_n_next = !(next_strobe && !io_next);
	wire              io_strb_n_next  = !(next_strobe && io_next);
	wire              msc_next        = !next_last;

	always_comb begin
		state_next = state_reg;
		sws_next   = sws_reg;
		wcnt_next  = wcnt_reg;
		hcnt_next  = hcnt_reg;
		write_next = write_reg;
		io_next    = io_reg;
		space_next = space_reg;
		addr_next  = addr_reg;
		case (state_reg)
			EWH_IDLE: begin
				// RULE10 fields latched once per cycle
				if (take_req) begin
					state_next = EWH_SETUP;
					sws_next   = req_sws;
					write_next = req_write;
					io_next    = is_io_req;
					space_next = req_space;
					addr_next  = req_addr_x;
				end else if (hold_s) begin
					state_next = EWH_HOLD;
					hcnt_next  = EWH_HOLD_MIN_CYC;
				end
			end
			EWH_SETUP: begin
				wcnt_next = sws_reg;
				if (sws_reg == '0) begin
					state_next = EWH_END;
				end else begin
					state_next = EWH_SWAIT;
				end
			end
			EWH_SWAIT: begin
				wcnt_next = wcnt_reg - SWS_W'(1);
				// RULE2 ready seen after last wait
				if (sws_last) begin
					if (ready_used && !ready_s) begin
						state_next = EWH_RWAIT;
					end else begin
						state_next = EWH_END;
					end
				end
			end
			EWH_RWAIT: begin
				if (ready_s) begin
					state_next = EWH_END;
				end
			end
			EWH_END: begin
				state_next = EWH_IDLE;
			end
			EWH_HOLD: begin
				// RULE7 minimum grant time
				if (!hold_min_ok) begin
					hcnt_next = hcnt_reg - 2'h1;
				end else if (!hold_s) begin
					state_next = EWH_REDRIVE;
				end
			end
			EWH_REDRIVE: begin
				// RULE9 re-drive before next cycle
				state_next = EWH_IDLE;
			end
			default: begin
				state_next = EWH_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= EWH_IDLE;
			sws_reg   <= '0;
			wcnt_reg  <= '0;
			hcnt_reg  <= 2'h0;
			write_reg <= 1'b0;
			io_reg    <= 1'b0;
			space_reg <= EWH_SP_PROG;
			addr_reg  <= ADDR_W'(EWH_ADDR_RST);
		end else if (ce) begin
			state_reg <= state_next;
			sws_reg   <= sws_next;
			wcnt_reg  <= wcnt_next;
			hcnt_reg  <= hcnt_next;
			write_reg <= write_next;
			io_reg    <= io_next;
			space_reg <= space_next;
			addr_reg  <= addr_next;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			req_ready_reg  <= 1'b0;
			cyc_done_reg   <= 1'b0;
			bus_oe_reg     <= 1'b1;
			prog_sel_n_reg <= 1'b1;
			data_sel_n_reg <= 1'b1;
			io_sel_n_reg   <= 1'b1;
			rw_reg         <= 1'b1;
			mem_strb_n_reg <= 1'b1;
			io_strb_n_reg  <= 1'b1;
			grant_n_reg    <= 1'b1;
			msc_reg        <= 1'b1;
		end else if (ce) begin
			req_ready_reg  <= req_ready_next;
			cyc_done_reg   <= cyc_done_next;
			bus_oe_reg     <= bus_oe_next;
			prog_sel_n_reg <= prog_sel_n_next;
			data_sel_n_reg <= data_sel_n_next;
			io_sel_n_reg   <= io_sel_n_next;
			rw_reg         <= rw_next;
			mem_strb_n_reg <= mem_strb_n_next;
			io_strb_n_reg  <= io_strb_n_next;
			grant_n_reg    <= grant_n_next;
			msc_reg        <= msc_next;
		end
	end

	assign req_ready            = req_ready_reg;
	assign cyc_done             = cyc_done_reg;
	assign addr_o               = addr_reg;
	assign addr_oe              = bus_oe_reg;
	assign rw_oe                = bus_oe_reg;
	assign strb_oe              = bus_oe_reg;
	assign program_space_sel_n  = prog_sel_n_reg;
	assign data_space_sel_n     = data_sel_n_reg;
	assign io_space_sel_n       = io_sel_n_reg;
	assign rw_o                 = rw_reg;
	assign mem_strobe_n         = mem_strb_n_reg;
	assign io_strobe_n          = io_strb_n_reg;
	assign bus_hold_grant_n     = grant_n_reg;
	assign micro_state_complete = msc_reg;
endmodule

// ==== ewh_bus_ctrl_assertions.sv ====
// port assertions
module ewh_bus_ctrl_chk (
	input wire logic        mclk,                 // system clock
	input wire logic        rst,                  // async reset, high
	input wire logic        req_ready,            // request taken
	input wire logic        cyc_done,             // cycle finished pulse
	input wire logic        addr_oe,              // address enable
	input wire logic        rw_oe,                // read/write enable
	input wire logic        strb_oe,              // strobe enable
	input wire logic        mem_strobe_n,         // memory strobe
	input wire logic        io_strobe_n,          // io strobe
	input wire logic        bus_hold_grant_n,     // hold grant, low
	input wire logic        micro_state_complete, // low in last state
	input wire logic [22:0] addr_o                // address out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence bus_redriven;
		addr_oe && rw_oe && strb_oe && mem_strobe_n && io_strobe_n && !req_ready;
	endsequence
	sequence cycle_close;
		cyc_done && mem_strobe_n && io_strobe_n;
	endsequence
	hold_float_a:
	assert property (!bus_hold_grant_n |-> !(addr_oe|rw_oe|strb_oe|req_ready)) else $error("hold");
	addr_hold_a:
	assert property (!mem_strobe_n && !$past(mem_strobe_n) |-> $stable(addr_o)) else $error("addr");
	io_addr_hold_a:
	assert property (!io_strobe_n && !$past(io_strobe_n) |-> $stable(addr_o)) else $error("io addr");
	strobe_excl_a:
	assert property (!(!mem_strobe_n && !io_strobe_n)) else $error("two strobes");
	grant_min_a:
	assert property ($fell(bus_hold_grant_n) |=> !bus_hold_grant_n) else $error("short grant");
	redrive_a:
	assert property ($rose(bus_hold_grant_n) |-> bus_redriven) else $error("no redrive");
	last_state_a:
	assert property (!micro_state_complete |=> cycle_close) else $error("last state");
endmodule
bind ewh_bus_ctrl ewh_bus_ctrl_chk chk_u (.*);

// ==== ewh_far_end.sv ====
// far side model
module ewh_far_end (input wire logic mclk, mem_strobe_n, output logic ready_pin, hold_req_n);
	timeunit 1ns/1ps;
	logic [7:0] cnt_reg = 8'h00;
	always @(posedge mclk) cnt_reg <= cnt_reg + 8'h01;
	assign ready_pin = mem_strobe_n | cnt_reg[1];
	assign hold_req_n = cnt_reg[7:4] != 4'h9;
endmodule

// ==== test_ext_bus_wait_and_hold.sv ====
// random bus cycle bench
module test_ext_bus_wait_and_hold;
	timeunit 1ns;
	timeprecision 1ps;
	import ewh_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic        req_dma = 1'b0;
	logic [1:0]  req_space = 2'h0;
	logic [22:0] req_addr = 23'h00_0000;
	logic [2:0]  req_sws = 3'h0;
	logic        ready_pin, hold_req_n;
	logic        cyc_done, addr_oe, program_space_sel_n, data_space_sel_n, io_space_sel_n;
	logic        rw_o, rw_oe, req_ready, mem_strobe_n, io_strobe_n, strb_oe;
	logic        bus_hold_grant_n, micro_state_complete;
	logic [22:0] addr_o;
	logic [31:0] lfsr = 32'h0000_cc1d;
	logic [1:0]  sp;
	int          errors = 0;
	int          cmp_count = 0;
	int          hold_cycles = 0;

	always #12.5 mclk = ~mclk;

	ewh_bus_ctrl dut_u (.*);
	ewh_far_end far_u (.*);

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h8020_0003)};
	endfunction

	function automatic logic [22:0] exp_addr(input logic [22:0] a, input logic dma,
		input logic [1:0] spc);
		if (dma || spc == EWH_SP_PROG) begin
			return a;
		end
		return {7'h00, a[15:0]};
	endfunction

	function automatic logic [2:0] exp_sel(input logic [1:0] spc);
		return {spc != EWH_SP_PROG, spc != EWH_SP_DATA, spc != EWH_SP_IO};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic bus_cycle(input logic wr, input logic dma, input logic [1:0] spc,
		input logic [22:0] adr, input logic [2:0] sws);
		int lows;
		lows = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_dma   <= dma;
		req_space <= spc;
		req_addr  <= adr;
		req_sws   <= sws;
		do @(negedge mclk); while (req_ready !== 1'b1);
		@(posedge mclk);
		req_valid <= 1'b0;
		do begin
			@(negedge mclk);
			if (mem_strobe_n === 1'b0 || io_strobe_n === 1'b0) begin
				lows++;
				check(addr_o, exp_addr(adr, dma, spc));
				check(io_strobe_n, spc != EWH_SP_IO);
				check(mem_strobe_n, spc == EWH_SP_IO);
				check(rw_o, !wr);
				check({program_space_sel_n, data_space_sel_n, io_space_sel_n}, exp_sel(spc));
			end
		end while (cyc_done !== 1'b1);
		if (sws < EWH_MIN_SWS) begin
			check(lows, int'(sws) + 1);
		end else begin
			check(lows >= int'(sws) + 1, 1'b1);
		end
		check(bus_hold_grant_n, 1'b1);
	endtask

	always @(negedge mclk) begin
		if (!rst && bus_hold_grant_n === 1'b0) begin
			hold_cycles++;
			check({addr_oe, rw_oe, strb_oe, req_ready}, 4'h0);
		end
	end

	// about 2000 cycles expected, 1 ms is far beyond
	initial begin
		#1ms;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		// corners: zero, one, two and seven waits
		bus_cycle(1'b0, 1'b0, EWH_SP_DATA, 23'h7f_1234, 3'h0);
		bus_cycle(1'b1, 1'b0, EWH_SP_IO, 23'h55_00aa, 3'h1);
		bus_cycle(1'b0, 1'b1, EWH_SP_IO, 23'h7f_ffff, 3'h2);
		bus_cycle(1'b1, 1'b0, EWH_SP_PROG, 23'h6a_5a5a, 3'h7);
		repeat (196) begin
			lfsr = lfsr_next(lfsr);
			sp = (lfsr[24:23] == 2'h3) ? EWH_SP_DATA : lfsr[24:23];
			bus_cycle(lfsr[26], lfsr[25], sp, lfsr[22:0], lfsr[29:27]);
		end
		check(hold_cycles > 0, 1'b1);
		report_and_stop();
	end
endmodule
